// [ufs_defs.svh]
// Register offsets, field positions, reset values and timing counts of the receive flag block.
`ifndef UFS_DEFS_SVH
`define UFS_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define UFS_OFS_STATUS    8'h00
`define UFS_OFS_RXDATA    8'h04
`define UFS_OFS_FILL      8'h08
`define UFS_OFS_CTRL      8'h0c
`define UFS_OFS_ETU       8'h10
`define UFS_OFS_IRQ_STAT  8'h14
`define UFS_OFS_IRQ_MASK  8'h18

// ****************************************************************
// Status register fields
// ****************************************************************
`define UFS_ST_FER   3
`define UFS_ST_PER   2
`define UFS_ST_RDF   1
`define UFS_ST_DR    0

// ****************************************************************
// Control register fields
// ****************************************************************
`define UFS_CT_TRIG_LO  0
`define UFS_CT_TRIG_HI  1
`define UFS_CT_ECEN     2
`define UFS_CT_PAR_EN   3
`define UFS_CT_ODD      4
`define UFS_CT_SYNC     5
`define UFS_CT_RESUME   6
`define UFS_CT_W        6
`define UFS_CTRL_RST    6'h00

// ****************************************************************
// Interrupt status and mask fields
// ****************************************************************
`define UFS_IRQ_RDF     0
`define UFS_IRQ_DR      1
`define UFS_IRQ_ERR     2
`define UFS_IRQ_W       3

// ****************************************************************
// Trigger numbers and timing
// ****************************************************************
`define UFS_TRIG_0      5'h01
`define UFS_TRIG_1      5'h04
`define UFS_TRIG_2      5'h08
`define UFS_TRIG_3      5'h0e
`define UFS_IDLE_ETU    5'h10
`define UFS_ETU_RST     16'h0364

`endif

// [ufs_pkg.sv]
// Types shared by the receive flag block.
package ufs_pkg;

  typedef struct packed {
    logic       framing_fault_flag;
    logic       parity_fault_flag;
    logic [7:0] data;
  } ufs_entry_t;

  typedef enum logic [0:0] {
    UFS_RX_RUN  = 1'b0,
    UFS_RX_HALT = 1'b1
  } ufs_rx_state_t;

endpackage : ufs_pkg

// [ufs_fifo_if.sv]
// Interface between the flag logic and its receive FIFO.
`timescale 1ns/1ps
interface ufs_fifo_if #(parameter int CW = 5);
  import ufs_pkg::*;
  logic            push;
  ufs_entry_t      push_entry;
  logic            pop;
  logic            flush;
  ufs_entry_t      head;
  logic [CW-1:0]   count;
  logic            empty;
  logic            full;

  modport store (input push, push_entry, pop, flush, output head, count, empty, full);
  modport user  (output push, push_entry, pop, flush, input head, count, empty, full);
endinterface : ufs_fifo_if

// [ufs_rx_fifo.sv]
// Receive FIFO holding data bytes with their error tags.
`timescale 1ns/1ps
module ufs_rx_fifo
  import ufs_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  ufs_fifo_if.store f
);

  initial begin
    if (DEPTH != (1 << AW)) $error("ufs_rx_fifo: DEPTH must be 2**AW");
    if ($bits(f.count) != AW + 1) $error("ufs_rx_fifo: count width must be AW+1");
  end

  ufs_entry_t    mem [DEPTH];
  logic [AW-1:0] wr_reg, wr_next;
  logic [AW-1:0] rd_reg, rd_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          do_push;
  logic          do_pop;

  assign do_push = f.push && !f.full && !f.flush;
  assign do_pop  = f.pop && !f.empty && !f.flush;

  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (f.flush) begin
      wr_next  = '0;
      rd_next  = '0;
      cnt_next = '0;
    end else begin
      if (do_push) wr_next = wr_reg + 1'b1;
      if (do_pop)  rd_next = rd_reg + 1'b1;
      if (do_push && !do_pop) cnt_next = cnt_reg + 1'b1;
      if (do_pop && !do_push) cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset; the head is only trusted while the FIFO is not empty.
  always_ff @(posedge hclk) begin
    if (do_push) mem[wr_reg] <= f.push_entry;
  end

  assign f.head  = mem[rd_reg];
  assign f.count = cnt_reg;
  assign f.empty = (cnt_reg == '0);
  assign f.full  = (cnt_reg == DEPTH[AW:0]);

endmodule : ufs_rx_fifo

// [ufs_idle_timer.sv]
// Idle timeout counter in bit periods for the leftover-data flag.
`timescale 1ns/1ps
module ufs_idle_timer #(
  parameter int EW = 16
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic [EW-1:0] etu_cycles,
  input  wire logic          restart,
  input  wire logic          hold,
  input  wire logic          idle,
  output logic               timeout
);
`include "ufs_defs.svh"

  initial begin
    if (EW < 2) $error("ufs_idle_timer: EW too small");
  end

  logic [EW-1:0] cyc_reg, cyc_next;
  logic [4:0]    etu_reg, etu_next;
  logic          to_reg, to_next;

  always_comb begin
    cyc_next = cyc_reg;
    etu_next = etu_reg;
    to_next  = 1'b0;
    if (restart || idle) begin
      cyc_next = '0;
      etu_next = '0;
    end else if (!hold && etu_reg != `UFS_IDLE_ETU) begin
      if (cyc_reg >= etu_cycles - 1'b1) begin
        cyc_next = '0;
        etu_next = etu_reg + 1'b1;
        to_next  = (etu_next == `UFS_IDLE_ETU);
      end else begin
        cyc_next = cyc_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_reg <= '0;
      etu_reg <= '0;
      to_reg  <= 1'b0;
    end else begin
      cyc_reg <= cyc_next;
      etu_reg <= etu_next;
      to_reg  <= to_next;
    end
  end

  assign timeout = to_reg;

endmodule : ufs_idle_timer

// [ufs_rx_flags.sv]
// Receive status flags, receive FIFO and AHB-Lite register slave.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Framing flag follows byte at read head.
// R2 - Parity flag follows head byte, asynchronous only.
// R3 - Reset and standby clear all four flags.
// R4 - Threshold flag sets when count reaches trigger.
// R5 - Software clears threshold: drain, read, write 0.
// R6 - DMA draining below trigger clears threshold.
// R7 - Receive FIFO holds sixteen bytes.
// R8 - Reading an empty FIFO returns undefined data.
// R9 - Fill count register low byte holds count.
// R10 - Idle flag: below trigger, 16 bits idle.
// R11 - Software clears idle flag by writing 0.
// R12 - Software should drain FIFO before clearing idle.
// R13 - Timeout counted in bit periods.
// R14 - Faulty bytes stored; halt unless continue enabled.
// R15 - Only first stop bit checked for framing.
// R16 - Each entry carries framing and parity tags.
// R17 - Idle counter restarts, holds, sleeps when empty.
module ufs_rx_flags
  import ufs_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        standby,
  input  wire logic        rx_done,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_parity_bit,
  input  wire logic        rx_stop1,
  output logic             rx_halted,
  output logic             dma_req,
  input  wire logic        dma_pop,
  output logic [7:0]       dma_data,
  output logic             dma_data_valid,
  output logic             irq
);
`include "ufs_defs.svh"

  initial begin
    if (DEPTH != 16 || AW != 4) $error("ufs_rx_flags: trigger table assumes a 16-entry FIFO");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  logic [`UFS_CT_W-1:0]  ctrl_reg, ctrl_next;
  logic [15:0]           etu_reg, etu_next;
  logic                  fer_reg, fer_next;
  logic                  per_reg, per_next;
  logic                  rdf_reg, rdf_next;
  logic                  dr_reg, dr_next;
  logic                  rdf_armed_reg, rdf_armed_next;
  logic [`UFS_IRQ_W-1:0] ist_reg, ist_next;
  logic [`UFS_IRQ_W-1:0] imask_reg, imask_next;
  ufs_rx_state_t         rx_state_reg, rx_state_next;
  logic                  dph_reg, dph_next;
  logic                  dwr_reg, dwr_next;
  logic [7:0]            daddr_reg, daddr_next;
  logic [31:0]           rdata_reg, rdata_next;
  logic [7:0]            dma_data_reg, dma_data_next;
  logic                  dma_vld_reg, dma_vld_next;

  ufs_fifo_if #(.CW(AW + 1)) fif ();

  logic        aph;
  logic        cpu_pop;
  logic        dma_take;
  logic        frame_err;
  logic        par_err;
  logic [4:0]  trig;
  logic        above;
  logic        timeout;
  logic        wr_status;
  logic        wr_ctrl;
  logic        wr_etu;
  logic        wr_ist;
  logic        wr_imask;
  logic [`UFS_IRQ_W-1:0] ev;

  // ****************************************************************
  // Receive FIFO and idle timer
  // ****************************************************************
  ufs_rx_fifo #(.DEPTH(DEPTH), .AW(AW)) u_fifo (  // see R7
    .hclk    (hclk),
    .hresetn (hresetn),
    .f       (fif.store)
  );

  ufs_idle_timer #(.EW(16)) u_timer (  // see R13
    .hclk       (hclk),
    .hresetn    (hresetn),
    .etu_cycles (etu_reg),
    .restart    (rx_done || standby),  // see R17
    .hold       (above),               // see R17
    .idle       (fif.empty),           // see R17
    .timeout    (timeout)
  );

  // ****************************************************************
  // Receive side
  // ****************************************************************
  always_comb begin
    case (ctrl_reg[`UFS_CT_TRIG_HI:`UFS_CT_TRIG_LO])
      2'h0:    trig = `UFS_TRIG_0;
      2'h1:    trig = `UFS_TRIG_1;
      2'h2:    trig = `UFS_TRIG_2;
      default: trig = `UFS_TRIG_3;
    endcase
  end

  assign above = (fif.count >= trig);

  // The second stop bit never reaches this block, so it cannot raise a fault.
  assign frame_err = !ctrl_reg[`UFS_CT_SYNC] && !rx_stop1;  // see R15
  assign par_err   = !ctrl_reg[`UFS_CT_SYNC] && ctrl_reg[`UFS_CT_PAR_EN]
                     && ((^{rx_byte, rx_parity_bit}) ^ ctrl_reg[`UFS_CT_ODD]);  // see R2

  // A faulty byte is stored before reception halts, as software must see it.
  assign fif.push             = rx_done && rx_state_reg == UFS_RX_RUN && !standby;  // see R14
  assign fif.push_entry.framing_fault_flag   = frame_err;  // see R16
  assign fif.push_entry.parity_fault_flag   = par_err;    // see R16
  assign fif.push_entry.data  = rx_byte;
  assign fif.flush            = standby;

  always_comb begin
    rx_state_next = rx_state_reg;
    case (rx_state_reg)
      UFS_RX_RUN: begin
        if (fif.push && (frame_err || par_err) && !ctrl_reg[`UFS_CT_ECEN]) begin
          rx_state_next = UFS_RX_HALT;  // see R14
        end
      end
      UFS_RX_HALT: begin
        if (wr_ctrl && hwdata[`UFS_CT_RESUME]) rx_state_next = UFS_RX_RUN;
      end
      default: rx_state_next = UFS_RX_RUN;
    endcase
    if (standby) rx_state_next = UFS_RX_RUN;
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Reads are decoded in the address phase so that a data port read pops exactly once.
  assign aph       = hsel && htrans[1] && hready;
  assign cpu_pop   = aph && !hwrite && haddr == `UFS_OFS_RXDATA;
  // The CPU wins a same-cycle pop; the DMA retries on its next request.
  assign dma_take  = dma_pop && !cpu_pop && !fif.empty;
  assign fif.pop   = cpu_pop || dma_take;
  assign wr_status = dph_reg && dwr_reg && daddr_reg == `UFS_OFS_STATUS;
  assign wr_ctrl   = dph_reg && dwr_reg && daddr_reg == `UFS_OFS_CTRL;
  assign wr_etu    = dph_reg && dwr_reg && daddr_reg == `UFS_OFS_ETU;
  assign wr_ist    = dph_reg && dwr_reg && daddr_reg == `UFS_OFS_IRQ_STAT;
  assign wr_imask  = dph_reg && dwr_reg && daddr_reg == `UFS_OFS_IRQ_MASK;

  always_comb begin
    dph_next   = aph;
    dwr_next   = aph && hwrite;
    daddr_next = aph ? haddr : daddr_reg;
    rdata_next = '0;
    if (aph && !hwrite) begin
      case (haddr)
        `UFS_OFS_STATUS: begin
          rdata_next[`UFS_ST_FER] = fer_reg;
          rdata_next[`UFS_ST_PER] = per_reg;
          rdata_next[`UFS_ST_RDF] = rdf_reg;
          rdata_next[`UFS_ST_DR]  = dr_reg;
        end
        `UFS_OFS_RXDATA:   rdata_next[7:0] = fif.head.data;  // see R8
        `UFS_OFS_FILL:     rdata_next[7:0] = 8'(fif.count);   // see R9
        `UFS_OFS_CTRL:     rdata_next[`UFS_CT_W-1:0] = ctrl_reg;
        `UFS_OFS_ETU:      rdata_next[15:0] = etu_reg;
        `UFS_OFS_IRQ_STAT: rdata_next[`UFS_IRQ_W-1:0] = ist_reg;
        `UFS_OFS_IRQ_MASK: rdata_next[`UFS_IRQ_W-1:0] = imask_reg;
        default:           rdata_next = '0;
      endcase
    end
  end

  // ****************************************************************
  // Configuration and flags
  // ****************************************************************
  always_comb begin
    ctrl_next      = ctrl_reg;
    etu_next       = etu_reg;
    fer_next       = fer_reg;
    per_next       = per_reg;
    rdf_next       = rdf_reg;
    dr_next        = dr_reg;
    rdf_armed_next = rdf_armed_reg;
    dma_data_next  = dma_data_reg;
    dma_vld_next   = dma_take;
    if (wr_ctrl) begin
      ctrl_next = hwdata[`UFS_CT_W-1:0];
      ctrl_next[`UFS_CT_RESUME] = 1'b0;
    end
    if (wr_etu && hwdata[15:0] != 16'h0000) etu_next = hwdata[15:0];
    if (dma_take) dma_data_next = fif.head.data;
    // Fault flags mirror the entry now at the read head and hold once it is empty.
    if (!fif.empty) begin
      fer_next = fif.head.framing_fault_flag;  // see R1
      per_next = fif.head.parity_fault_flag;  // see R2
    end
    if (aph && !hwrite && haddr == `UFS_OFS_STATUS && rdf_reg) rdf_armed_next = 1'b1;
    if (wr_status && !hwdata[`UFS_ST_RDF] && rdf_armed_reg && !above) begin
      rdf_next       = 1'b0;  // see R5
      rdf_armed_next = 1'b0;
    end
    // The DMA clear judges the count left after its pop, so the last pop clears as well.
    if (dma_take && !fif.push && fif.count <= trig) begin
      rdf_next = 1'b0;  // see R6
    end else if (above) begin
      rdf_next = 1'b1;  // see R4
    end
    if (wr_status && !hwdata[`UFS_ST_DR]) dr_next = 1'b0;  // see R11
    if (timeout && !above) dr_next = 1'b1;    // see R10
    if (standby) begin
      fer_next       = 1'b0;  // see R3
      per_next       = 1'b0;
      rdf_next       = 1'b0;
      dr_next        = 1'b0;
      rdf_armed_next = 1'b0;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign ev[`UFS_IRQ_RDF] = rdf_next && !rdf_reg;
  assign ev[`UFS_IRQ_DR]  = dr_next && !dr_reg;
  assign ev[`UFS_IRQ_ERR] = fif.push && (frame_err || par_err);

  always_comb begin
    imask_next = wr_imask ? hwdata[`UFS_IRQ_W-1:0] : imask_reg;
    ist_next   = ist_reg;
    if (wr_ist) ist_next = ist_reg & ~hwdata[`UFS_IRQ_W-1:0];
    ist_next = ist_next | ev;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg      <= `UFS_CTRL_RST;
      etu_reg       <= `UFS_ETU_RST;
      fer_reg       <= 1'b0;  // see R3
      per_reg       <= 1'b0;
      rdf_reg       <= 1'b0;
      dr_reg        <= 1'b0;
      rdf_armed_reg <= 1'b0;
      ist_reg       <= '0;
      imask_reg     <= '0;
      rx_state_reg  <= UFS_RX_RUN;
      dph_reg       <= 1'b0;
      dwr_reg       <= 1'b0;
      daddr_reg     <= '0;
      rdata_reg     <= '0;
      dma_data_reg  <= '0;
      dma_vld_reg   <= 1'b0;
    end else begin
      ctrl_reg      <= ctrl_next;
      etu_reg       <= etu_next;
      fer_reg       <= fer_next;
      per_reg       <= per_next;
      rdf_reg       <= rdf_next;
      dr_reg        <= dr_next;
      rdf_armed_reg <= rdf_armed_next;
      ist_reg       <= ist_next;
      imask_reg     <= imask_next;
      rx_state_reg  <= rx_state_next;
      dph_reg       <= dph_next;
      dwr_reg       <= dwr_next;
      daddr_reg     <= daddr_next;
      rdata_reg     <= rdata_next;
      dma_data_reg  <= dma_data_next;
      dma_vld_reg   <= dma_vld_next;
    end
  end

  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = rdata_reg;
  assign rx_halted      = (rx_state_reg == UFS_RX_HALT);
  assign dma_req        = rdf_reg;
  assign dma_data       = dma_data_reg;
  assign dma_data_valid = dma_vld_reg;
  assign irq            = |(ist_reg & imask_reg);

endmodule : ufs_rx_flags

// [ufs_rx_flags_sva.sv]
// Port-level assertion checker for the receive flag block.
`timescale 1ns/1ps
module ufs_rx_flags_chk #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        standby,
  input wire logic        rx_halted,
  input wire logic        dma_req,
  input wire logic        dma_pop,
  input wire logic [7:0]  dma_data,
  input wire logic        dma_data_valid,
  input wire logic        irq
);
  // ****************************************************************
  // Sequences and assertions
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_no_read;
    hready && !(hsel && htrans[1] && !hwrite);
  endsequence

  sequence s_no_pop;
    !dma_pop;
  endsequence

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_hrdata_idle: assert property (s_no_read ##1 1'b1 |-> hrdata == 32'h0)
    else $error("read data present without a read");
  a_reset_quiet: assert property (!$past(hresetn) |->
    !dma_req && !rx_halted && !irq && !dma_data_valid && hrdata == 32'h0)
    else $error("outputs not quiet after reset");
  a_standby_clear: assert property (standby |=> !dma_req && !rx_halted)
    else $error("standby did not clear flags");
  a_valid_cause: assert property (dma_data_valid |-> $past(dma_pop))
    else $error("dma data valid without a pop");
  a_no_pop_valid: assert property (s_no_pop |=> !dma_data_valid)
    else $error("dma data valid after idle cycle");
  a_data_hold: assert property (!dma_data_valid |-> $stable(dma_data))
    else $error("dma data changed without a pop");
  a_req_fall: assert property ($fell(dma_req) |-> $past(dma_pop || standby || hsel, 1) ||
    $past(dma_pop || standby || hsel, 2) || $past(dma_pop || standby || hsel, 3))
    else $error("threshold request dropped without a cause");
endmodule : ufs_rx_flags_chk

bind ufs_rx_flags ufs_rx_flags_chk #(.DEPTH(DEPTH), .AW(AW)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .standby(standby), .rx_halted(rx_halted), .dma_req(dma_req), .dma_pop(dma_pop),
  .dma_data(dma_data), .dma_data_valid(dma_data_valid), .irq(irq)
);

// [ufs_rx_source.sv]
// Behavioural remote transmitter handing received characters to the flag block.
`timescale 1ns/1ps
module ufs_rx_source (
  input  wire logic       hclk,
  input  wire logic       send,
  input  wire logic [7:0] tx_val,
  input  wire logic       bad_stop,
  input  wire logic       bad_par,
  output logic            rx_done,
  output logic [7:0]      rx_byte,
  output logic            rx_parity_bit,
  output logic            rx_stop1
);
  initial begin
    rx_done = 1'b0;
    rx_byte = 8'h00;
    rx_parity_bit = 1'b0;
    rx_stop1 = 1'b1;
  end

  always @(posedge hclk) begin
    rx_done <= send;
    if (send) begin
      rx_byte <= tx_val;
      rx_parity_bit <= (^tx_val) ^ bad_par;
      rx_stop1 <= ~bad_stop;
    end else begin
      // Stale lines are inverted so that an old byte is never taken for a new one.
      rx_byte <= ~rx_byte;
      rx_parity_bit <= ~rx_parity_bit;
      rx_stop1 <= ~rx_stop1;
    end
  end
endmodule : ufs_rx_source

// [test_ufs_rx_flags.sv]
// Self-checking testbench for the receive flag block.
`timescale 1ns/1ps
`include "ufs_defs.svh"
module test_ufs_rx_flags;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        standby = 1'b0;
  logic        dma_pop = 1'b0;
  logic        send = 1'b0;
  logic        bad_stop = 1'b0;
  logic        bad_par = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [7:0]  tx_val = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, rx_done, rx_parity_bit, rx_stop1;
  logic        rx_halted, dma_req, dma_data_valid, irq;
  logic [7:0]  rx_byte, dma_data, b;
  logic [7:0]  v[4];
  logic [7:0]  q[$];
  int          fails = 0;
  int          check_count = 0;

  always #5 hclk = ~hclk;

  ufs_rx_flags #(.DEPTH(16), .AW(4)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .standby(standby),
    .rx_done(rx_done), .rx_byte(rx_byte), .rx_parity_bit(rx_parity_bit),
    .rx_stop1(rx_stop1), .rx_halted(rx_halted), .dma_req(dma_req), .dma_pop(dma_pop),
    .dma_data(dma_data), .dma_data_valid(dma_data_valid), .irq(irq)
  );

  ufs_rx_source src (
    .hclk(hclk), .send(send), .tx_val(tx_val), .bad_stop(bad_stop), .bad_par(bad_par),
    .rx_done(rx_done), .rx_byte(rx_byte), .rx_parity_bit(rx_parity_bit),
    .rx_stop1(rx_stop1)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    // Read data is taken at the edge that ends the data phase, before the registers move.
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic rx(input logic [7:0] val, input logic f, input logic p);
    @(posedge hclk);
    send <= 1'b1;
    tx_val <= val;
    bad_stop <= f;
    bad_par <= p;
    @(posedge hclk);
    send <= 1'b0;
  endtask : rx

  task automatic sby;
    @(posedge hclk);
    standby <= 1'b1;
    @(posedge hclk);
    standby <= 1'b0;
  endtask : sby

  function automatic logic [31:0] st(input logic f, input logic p, input logic t,
                                     input logic d);
    return {28'h0, f, p, t, d};
  endfunction : st

  function automatic int trig(input int s);
    case (s)
      0: return int'(`UFS_TRIG_0);
      1: return int'(`UFS_TRIG_1);
      2: return int'(`UFS_TRIG_2);
      default: return int'(`UFS_TRIG_3);
    endcase
  endfunction : trig

  task automatic tally_and_finish;
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    void'($urandom(29));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(`UFS_OFS_STATUS, 32'h0);
    rdchk(`UFS_OFS_ETU, 32'h364);
    rdchk(8'h1c, 32'h0);
    bus(1'b1, `UFS_OFS_ETU, 32'h2);
    bus(1'b1, `UFS_OFS_CTRL, 32'hd);
    for (int i = 0; i < 3; i++) begin
      v[i] = 8'($urandom);
      rx(v[i], i == 0, i == 1);
    end
    repeat (3) @(posedge hclk);
    rdchk(`UFS_OFS_FILL, 32'h3);
    rdchk(`UFS_OFS_STATUS, st(1, 0, 0, 0));
    rdchk(`UFS_OFS_RXDATA, {24'h0, v[0]});
    rdchk(`UFS_OFS_STATUS, st(0, 1, 0, 0));
    rdchk(`UFS_OFS_RXDATA, {24'h0, v[1]});
    rdchk(`UFS_OFS_STATUS, st(0, 0, 0, 0));
    repeat (20) @(posedge hclk);
    rdchk(`UFS_OFS_STATUS, st(0, 0, 0, 1));
    rdchk(`UFS_OFS_IRQ_STAT, 32'h6);
    chk(32'(irq), 32'h0);
    bus(1'b1, `UFS_OFS_IRQ_MASK, 32'h2);
    @(negedge hclk);
    chk(32'(irq), 32'h1);
    bus(1'b1, `UFS_OFS_IRQ_STAT, 32'h6);
    @(negedge hclk);
    chk(32'(irq), 32'h0);
    rdchk(`UFS_OFS_RXDATA, {24'h0, v[2]});
    bus(1'b1, `UFS_OFS_STATUS, 32'h0);
    rdchk(`UFS_OFS_STATUS, 32'h0);
    bus(1'b0, `UFS_OFS_RXDATA, 32'h0);
    rdchk(`UFS_OFS_FILL, 32'h0);
    bus(1'b1, `UFS_OFS_CTRL, 32'h9);
    rx(8'h5a, 1'b1, 1'b0);
    rx(8'ha5, 1'b0, 1'b0);
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk(32'(rx_halted), 32'h1);
    rdchk(`UFS_OFS_FILL, 32'h1);
    bus(1'b1, `UFS_OFS_CTRL, 32'h4d);
    @(negedge hclk);
    chk(32'(rx_halted), 32'h0);
    sby();
    rdchk(`UFS_OFS_STATUS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v[i] = 8'($urandom);
      rx(v[i], i == 1, 1'b0);
    end
    repeat (3) @(posedge hclk);
    rdchk(`UFS_OFS_STATUS, st(0, 0, 1, 0));
    rdchk(`UFS_OFS_RXDATA, {24'h0, v[0]});
    bus(1'b1, `UFS_OFS_STATUS, 32'h0);
    rdchk(`UFS_OFS_STATUS, st(1, 0, 0, 0));
    sby();
    rdchk(`UFS_OFS_FILL, 32'h0);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, `UFS_OFS_CTRL, 32'h4 | 32'(s));
      for (int i = 1; i <= 17; i++) begin
        b = 8'($urandom);
        rx(b, 1'b0, 1'($urandom));
        if (i <= 16) begin
          q.push_back(b);
        end
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk(32'(dma_req), 32'(i >= trig(s)));
      end
      rdchk(`UFS_OFS_FILL, 32'h10);
      @(posedge hclk);
      dma_pop <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 17; i++) begin
        @(negedge hclk);
        chk(32'(dma_data_valid), 32'(i < 16));
        if (i < 16) begin
          chk(32'(dma_data), 32'(q.pop_front()));
        end
      end
      @(posedge hclk);
      dma_pop <= 1'b0;
      @(negedge hclk);
      chk(32'(dma_req), 32'h0);
    end
    bus(1'b1, `UFS_OFS_CTRL, 32'h1c);
    rx(8'h03, 1'b0, 1'b1);
    rx(8'h03, 1'b0, 1'b0);
    bus(1'b1, `UFS_OFS_CTRL, 32'h3c);
    rx(8'h00, 1'b1, 1'b1);
    repeat (3) @(posedge hclk);
    rdchk(`UFS_OFS_STATUS, st(0, 0, 1, 0));
    rdchk(`UFS_OFS_RXDATA, 32'h3);
    rdchk(`UFS_OFS_STATUS, st(0, 1, 1, 0));
    rdchk(`UFS_OFS_RXDATA, 32'h3);
    rdchk(`UFS_OFS_STATUS, st(0, 0, 1, 0));
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge hclk);
    fails++;
    tally_and_finish();
  end
endmodule : test_ufs_rx_flags
